// File: aps_pkg.sv
// shared constants and types of the access policy switch decoder
package aps_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_SETTINGS = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_CLEAR    = 8'h08;
	localparam logic [7:0] ADDR_ENABLE   = 8'h0C;
	localparam logic [7:0] ADDR_REPORT   = 8'h10;

	// policy bank bit positions (switch n is bit n-1)
	localparam int POL_STRICT_EXIT  = 0;
	localparam int POL_VIOL_ONLY    = 3;
	localparam int POL_PRIV_CHECK   = 4;
	localparam int POL_STOP_FULL    = 5;
	localparam int POL_ALARM_FULL   = 6;
	localparam int POL_AUTO_ARM     = 7;

	// address bank bit positions
	localparam int ADR_LSB          = 0;
	localparam int ADR_MSB          = 3;
	localparam int ADR_SCAN_DIS     = 4;
	localparam int ADR_SUP_UNLOCK   = 7;

	// settings register field positions
	localparam int SET_POLICY_LSB   = 0;
	localparam int SET_ADDRESS_LSB  = 8;
	localparam int SET_SPARE_LSB    = 16;
	localparam int SET_VALID_BIT    = 24;

	// status, clear and enable bit positions
	localparam int EV_BUF_FULL      = 0;
	localparam int EV_AUTO_ARM      = 1;
	localparam int EV_TABLE_BAD     = 2;
	localparam int EV_DENIED        = 3;
	localparam int EV_W             = 4;

	// tag classes
	localparam logic [1:0] TAG_NORMAL     = 2'h0;
	localparam logic [1:0] TAG_PRIVILEGED = 2'h1;
	localparam logic [1:0] TAG_MASTER     = 2'h2;

	// display characters
	localparam logic [7:0] CH_A    = 8'h41;
	localparam logic [7:0] CH_D_LC = 8'h64;
	localparam logic [7:0] CH_E    = 8'h45;
	localparam logic [7:0] CH_R    = 8'h52;
	localparam logic [7:0] CH_0    = 8'h30;
	localparam logic [7:0] CH_1    = 8'h31;
	localparam logic [7:0] CH_HEXA = 8'h37; // 'A' minus ten
	localparam logic [7:0] CH_BLANK = 8'h20;

	// switch settling time before the one sample is taken
	localparam int CLK_PERIOD_NS = 5;
	localparam int SETTLE_NS     = 1000;
	localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// reset values
	localparam logic [EV_W-1:0] STATUS_RST = 4'h0;
	localparam logic [EV_W-1:0] ENABLE_RST = 4'h0;

	typedef enum logic [1:0] {
		APS_ST_SETTLE = 2'b00,
		APS_ST_RUN    = 2'b01,
		APS_ST_ERR    = 2'b10
	} aps_state_t;

endpackage

// File: aps_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module aps_sync #(
	parameter int W = 8
) (
	input  wire logic         mclk_i,
	input  wire logic         reset_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} aps_sync_t;

	aps_sync_t s_r;
	aps_sync_t s_nxt;

	// first stage feeds only the second stage
	always_comb begin
		s_nxt.meta   = async_i;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_o = s_r.stable;

endmodule

// File: aps_top.sv
// access policy switch decoder: samples switch banks, decides access, drives display
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module aps_top (
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	// switch and key pins
	input  wire logic [7:0]  policy_switch_bank_i,
	input  wire logic [7:0]  address_switch_bank_i,
	input  wire logic [7:0]  spare_switch_bank_i,
	input  wire logic        escape_key_i,
	// access requests from the policy logic
	input  wire logic        req_valid_i,
	input  wire logic        req_exit_i,
	input  wire logic        req_violation_i,
	input  wire logic [1:0]  req_tag_class_i,
	input  wire logic        privileged_inside_i,
	input  wire logic        buffer_full_i,
	input  wire logic        last_out_i,
	input  wire logic        table_check_done_i,
	input  wire logic        table_corrupt_i,
	// register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// decisions and settings
	output logic             grant_o,
	output logic             deny_o,
	output logic             store_txn_o,
	output logic [7:0]       store_unit_letter_o,
	output logic             buffer_alarm_o,
	output logic             arm_inputs_o,
	output logic             scanner_disable_mode_o,
	output logic [3:0]       unit_address_o,
	output logic [7:0]       unit_letter_o,
	output logic             settings_valid_o,
	output logic [31:0]      display_text_o,
	output logic             reinit_tables_o,
	output logic             irq_o
);

	typedef struct packed {
		aps_pkg::aps_state_t    state;
		logic [7:0]             settle_cnt;
		logic [7:0]             policy;
		logic [7:0]             address;
		logic [7:0]             spare;
		logic [7:0]             letter;
		logic                   valid;
		logic                   checked;
		logic                   esc_prev;
		logic                   full_prev;
		logic [aps_pkg::EV_W-1:0] status;
		logic [aps_pkg::EV_W-1:0] enable;
		logic [31:0]            rdata;
		logic                   grant;
		logic                   deny;
		logic                   store;
		logic                   alarm;
		logic                   arm;
		logic [31:0]            disp;
		logic                   reinit;
		logic                   irq;
	} aps_top_t;

	aps_top_t s_r;
	aps_top_t s_nxt;

	logic [7:0] pol_s;
	logic [7:0] adr_s;
	logic [7:0] spr_s;
	logic       esc_s;

	// every switch bank pin and the escape key pass two flip-flops before any logic reads them
	aps_sync #(
		.W (25)
	) u_sync (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.async_i   ({escape_key_i, spare_switch_bank_i, address_switch_bank_i,
		               policy_switch_bank_i}),
		.sync_o    ({esc_s, spr_s, adr_s, pol_s})
	);

	// letter of a four-bit address, 0 is A
	function automatic logic [7:0] addr_letter(input logic [3:0] a);
		addr_letter = aps_pkg::CH_A + {4'h0, a};
	endfunction

	// hex digit as a display character
	function automatic logic [7:0] hex_char(input logic [3:0] a);
		if (a < 4'hA) begin
			hex_char = aps_pkg::CH_0 + {4'h0, a};
		end else begin
			hex_char = aps_pkg::CH_HEXA + {4'h0, a};
		end
	endfunction

	// decoded settings
	logic [3:0]             uaddr;
	logic                   strict_exit;
	logic                   viol_only;
	logic                   priv_check;
	logic                   stop_full;
	logic                   alarm_full;
	logic                   auto_arm;
	logic                   sup_unlock;
	logic                   apb_hit;
	logic                   refuse;
	logic                   esc_rise;
	logic                   full_rise;
	logic [aps_pkg::EV_W-1:0] ev;

	// address from switches 1 to 4, switch 1 lsb
	assign uaddr       = s_r.address[aps_pkg::ADR_MSB:aps_pkg::ADR_LSB];
	assign strict_exit = s_r.policy[aps_pkg::POL_STRICT_EXIT];
	assign viol_only   = s_r.policy[aps_pkg::POL_VIOL_ONLY];
	assign priv_check  = s_r.policy[aps_pkg::POL_PRIV_CHECK];
	assign stop_full   = s_r.policy[aps_pkg::POL_STOP_FULL];
	assign alarm_full  = s_r.policy[aps_pkg::POL_ALARM_FULL];
	assign auto_arm    = s_r.policy[aps_pkg::POL_AUTO_ARM];
	assign sup_unlock  = s_r.address[aps_pkg::ADR_SUP_UNLOCK];
	assign esc_rise    = esc_s & ~s_r.esc_prev;
	assign full_rise   = buffer_full_i & ~s_r.full_prev;

	// access decision for the request in this cycle
	always_comb begin
		// privileged tags exempt unless checks are switched on
		apb_hit = req_violation_i &
		          ((req_tag_class_i != aps_pkg::TAG_PRIVILEGED) | priv_check);
		refuse  = 1'b0;
		// stop all access on a full buffer
		if (stop_full && buffer_full_i) begin
			refuse = 1'b1;
		// exits on violation refused only in strict mode
		end else if (apb_hit && (!req_exit_i || strict_exit)) begin
			refuse = 1'b1;
		// supervisor unlock holds normal tags out
		end else if (sup_unlock && req_tag_class_i == aps_pkg::TAG_NORMAL &&
		             !privileged_inside_i) begin
			refuse = 1'b1;
		end
	end

	// events that set sticky status bits
	always_comb begin
		ev = '0;
		ev[aps_pkg::EV_BUF_FULL]  = (s_r.state == aps_pkg::APS_ST_RUN) & full_rise;
		ev[aps_pkg::EV_AUTO_ARM]  = (s_r.state == aps_pkg::APS_ST_RUN) & last_out_i &
		                            auto_arm;
		ev[aps_pkg::EV_TABLE_BAD] = (s_r.state == aps_pkg::APS_ST_RUN) & !s_r.checked &
		                            table_check_done_i & table_corrupt_i;
		ev[aps_pkg::EV_DENIED]    = (s_r.state == aps_pkg::APS_ST_RUN) & req_valid_i &
		                            refuse;
	end

	// clear request decoded from a write to the clear register
	logic [aps_pkg::EV_W-1:0] clr_req;
	logic [aps_pkg::EV_W-1:0] status_upd;

	always_comb begin
		clr_req = '0;
		if (reg_wr_i && reg_addr_i == aps_pkg::ADDR_CLEAR) begin
			clr_req = reg_wdata_i[aps_pkg::EV_W-1:0];
		end
	end

	// sticky status per bit: an event in the clearing cycle wins over the clear
	genvar gi;
	generate
		for (gi = 0; gi < aps_pkg::EV_W; gi++) begin : g_status
			assign status_upd[gi] = ev[gi] | (s_r.status[gi] & ~clr_req[gi]);
		end
	endgenerate

	// next state of the whole block
	always_comb begin
		s_nxt           = s_r;
		s_nxt.grant     = 1'b0;
		s_nxt.deny      = 1'b0;
		s_nxt.store     = 1'b0;
		s_nxt.arm       = 1'b0;
		s_nxt.reinit    = 1'b0;
		s_nxt.rdata     = '0;
		s_nxt.esc_prev  = esc_s;
		s_nxt.full_prev = buffer_full_i;

		case (s_r.state)
			aps_pkg::APS_ST_SETTLE: begin
				// one sample after settling, held until reset
				if (s_r.settle_cnt == 8'(aps_pkg::SETTLE_CYC - 1)) begin
					s_nxt.policy  = pol_s;
					s_nxt.address = adr_s;
					s_nxt.spare   = spr_s;
					// letter kept in a register so the outputs need no adder
					s_nxt.letter  = addr_letter(adr_s[3:0]);
					s_nxt.valid   = 1'b1;
					s_nxt.state   = aps_pkg::APS_ST_RUN;
					s_nxt.disp    = {aps_pkg::CH_A, aps_pkg::CH_D_LC,
					                 aps_pkg::CH_0, hex_char(adr_s[3:0])};
				end else begin
					s_nxt.settle_cnt = s_r.settle_cnt + 8'h01;
				end
			end
			aps_pkg::APS_ST_RUN: begin
				if (!s_r.checked && table_check_done_i) begin
					s_nxt.checked = 1'b1;
					if (table_corrupt_i) begin
						s_nxt.state = aps_pkg::APS_ST_ERR;
						s_nxt.disp  = {aps_pkg::CH_E, aps_pkg::CH_R,
						               aps_pkg::CH_R, aps_pkg::CH_1};
					end
				end
				if (req_valid_i) begin
					s_nxt.grant = ~refuse;
					s_nxt.deny  = refuse;
					s_nxt.store = ~viol_only | req_violation_i;
				end
				// automatic arming on last person out
				s_nxt.arm = last_out_i & auto_arm;
			end
			aps_pkg::APS_ST_ERR: begin
				if (esc_rise) begin
					s_nxt.reinit = 1'b1;
					s_nxt.state  = aps_pkg::APS_ST_RUN;
					s_nxt.disp   = {aps_pkg::CH_A, aps_pkg::CH_D_LC,
					                aps_pkg::CH_0, hex_char(uaddr)};
				end
			end
			default: begin
				s_nxt.state = aps_pkg::APS_ST_SETTLE;
			end
		endcase

		// alarm level while full when enabled
		s_nxt.alarm = s_r.valid & alarm_full & buffer_full_i;

		// enable register write; status comes from the per-bit sticky logic
		if (reg_wr_i) begin
			if (reg_addr_i == aps_pkg::ADDR_ENABLE) begin
				s_nxt.enable = reg_wdata_i[aps_pkg::EV_W-1:0];
			end
		end
		s_nxt.status = status_upd;

		// register reads, answer one cycle later
		if (reg_rd_i) begin
			if (reg_addr_i == aps_pkg::ADDR_SETTINGS) begin
				s_nxt.rdata = {7'h00, s_r.valid, s_r.spare, s_r.address, s_r.policy};
			end else if (reg_addr_i == aps_pkg::ADDR_STATUS) begin
				s_nxt.rdata = {28'h0000000, s_r.status};
			end else if (reg_addr_i == aps_pkg::ADDR_ENABLE) begin
				s_nxt.rdata = {28'h0000000, s_r.enable};
			end else if (reg_addr_i == aps_pkg::ADDR_REPORT) begin
				s_nxt.rdata = {16'h0000, addr_letter(uaddr), 4'h0, uaddr};
			end else begin
				s_nxt.rdata = '0;
			end
		end

		// level interrupt follows the registered status and enable together
		s_nxt.irq = |(s_nxt.status & s_nxt.enable);
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			s_r            <= '0;
			s_r.state      <= aps_pkg::APS_ST_SETTLE;
			s_r.status     <= aps_pkg::STATUS_RST;
			s_r.enable     <= aps_pkg::ENABLE_RST;
			s_r.disp       <= {4{aps_pkg::CH_BLANK}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign reg_rdata_o            = s_r.rdata;
	assign grant_o                = s_r.grant;
	assign deny_o                 = s_r.deny;
	assign store_txn_o            = s_r.store;
	// address carried with each stored report
	assign store_unit_letter_o    = s_r.letter;
	assign buffer_alarm_o         = s_r.alarm;
	assign arm_inputs_o           = s_r.arm;
	assign scanner_disable_mode_o = s_r.address[aps_pkg::ADR_SCAN_DIS];
	assign unit_address_o         = uaddr;
	assign unit_letter_o          = s_r.letter;
	assign settings_valid_o       = s_r.valid;
	assign display_text_o         = s_r.disp;
	assign reinit_tables_o        = s_r.reinit;
	assign irq_o                  = s_r.irq;

endmodule

// File: aps_installer.sv
// installer model: switch banks as they are set on site
`timescale 1ns/10ps
module aps_installer (
	input  wire logic [7:0] pol_set_i,
	input  wire logic [7:0] adr_set_i,
	output logic      [7:0] policy_bank_o,
	output logic      [7:0] address_bank_o,
	output logic      [7:0] spare_bank_o
);
	// reserved switches off
	// policy 2,3 and address 6,7 stay off whatever is asked
	assign policy_bank_o  = pol_set_i & 8'hF9;
	assign address_bank_o = adr_set_i & 8'h9F;
	// spare bank off
	// the whole spare bank is left off
	assign spare_bank_o   = 8'h00;
endmodule

// File: aps_sva.sv
// concurrent checks on the switch decoder's ports
`timescale 1ns/10ps
module aps_sva (
	input wire logic        mclk_i,
	input wire logic        reset_n_i,
	input wire logic [7:0]  policy_switch_bank_i,
	input wire logic        req_valid_i,
	input wire logic        req_exit_i,
	input wire logic        req_violation_i,
	input wire logic [1:0]  req_tag_class_i,
	input wire logic        buffer_full_i,
	input wire logic        last_out_i,
	input wire logic        grant_o,
	input wire logic        deny_o,
	input wire logic        store_txn_o,
	input wire logic        buffer_alarm_o,
	input wire logic        arm_inputs_o,
	input wire logic [3:0]  unit_address_o,
	input wire logic [7:0]  unit_letter_o,
	input wire logic [31:0] display_text_o,
	input wire logic        settings_valid_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);
	// a request taken once the settings are valid and no table fault is shown
	wire logic [7:0] pol = policy_switch_bank_i;
	wire logic       run = settings_valid_o &
		(display_text_o != {aps_pkg::CH_E, aps_pkg::CH_R, aps_pkg::CH_R, aps_pkg::CH_1});
	wire logic       go  = req_valid_i & run;
	// one answer, then quiet unless a back to back request follows
	sequence s_answer;
		(grant_o ^ deny_o) ##1 (!(grant_o | deny_o) || $past(go));
	endsequence
	chk_one_answer: assert property (go |=> s_answer)
		else $error("request not answered once");
	chk_strict_exit: assert property (go && req_exit_i && req_violation_i &&
		req_tag_class_i == aps_pkg::TAG_NORMAL && pol[0] |=> deny_o)
		else $error("violating exit not refused");
	chk_store_sel: assert property (go |=>
		store_txn_o == (!$past(pol[3]) || $past(req_violation_i)))
		else $error("store decision wrong");
	chk_priv_exempt: assert property (go && req_tag_class_i == aps_pkg::TAG_PRIVILEGED &&
		!pol[4] && !(pol[5] && buffer_full_i) |=> grant_o)
		else $error("privileged tag not exempt");
	chk_full_stop: assert property (go && pol[5] && buffer_full_i |=> deny_o)
		else $error("access given with buffer full");
	chk_full_alarm: assert property (settings_valid_o |=>
		buffer_alarm_o == $past(pol[6] & buffer_full_i))
		else $error("buffer alarm wrong");
	chk_auto_arm: assert property (run && last_out_i |=>
		arm_inputs_o == $past(pol[7]))
		else $error("auto arm wrong");
	chk_letter_map: assert property (settings_valid_o |->
		unit_letter_o == 8'h41 + {4'h0, unit_address_o})
		else $error("unit letter wrong");
	chk_held_address: assert property (settings_valid_o && $past(settings_valid_o) |->
		$stable(unit_address_o) && $stable(unit_letter_o))
		else $error("unit address changed after sampling");
endmodule

// File: test_access_policy_switch_config.sv
// self-checking bench of the switch decoder
`timescale 1ns/10ps
bind aps_top aps_sva aps_sva_inst (
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .policy_switch_bank_i(policy_switch_bank_i),
	.req_valid_i(req_valid_i), .req_exit_i(req_exit_i), .req_violation_i(req_violation_i),
	.req_tag_class_i(req_tag_class_i), .buffer_full_i(buffer_full_i),
	.last_out_i(last_out_i), .grant_o(grant_o), .deny_o(deny_o), .store_txn_o(store_txn_o),
	.buffer_alarm_o(buffer_alarm_o), .arm_inputs_o(arm_inputs_o),
	.unit_address_o(unit_address_o), .unit_letter_o(unit_letter_o),
	.display_text_o(display_text_o), .settings_valid_o(settings_valid_o));
module test_access_policy_switch_config;
	// f: exit, violation, tag class(2), full, privileged inside, grant, store
	typedef struct packed {
		logic [7:0] p;
		logic [7:0] a;
		logic [7:0] f;
	} aps_row_t;
	logic        mclk_i = 1'h0, reset_n_i = 1'h0, escape_key_i = 1'h0;
	logic        req_valid_i = 1'h0, req_exit_i = 1'h0, req_violation_i = 1'h0;
	logic        privileged_inside_i = 1'h0, buffer_full_i = 1'h0, last_out_i = 1'h0;
	logic        table_check_done_i = 1'h0, table_corrupt_i = 1'h0;
	logic        reg_wr_i = 1'h0, reg_rd_i = 1'h0;
	logic [1:0]  req_tag_class_i = 2'h0;
	logic [7:0]  reg_addr_i = 8'h00, pol_set = 8'h00, adr_set = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	wire logic [7:0] policy_switch_bank_i, address_switch_bank_i, spare_switch_bank_i;
	logic [31:0] reg_rdata_o, display_text_o;
	logic [7:0]  store_unit_letter_o, unit_letter_o, lt;
	logic [3:0]  unit_address_o, am;
	logic        grant_o, deny_o, store_txn_o, buffer_alarm_o, arm_inputs_o;
	logic        scanner_disable_mode_o, settings_valid_o, reinit_tables_o, irq_o;
	int          n_fail = 0;
	int          n_compared = 0;
	int          k;
	aps_row_t    r;
	aps_row_t    rows [16] = '{
		'{8'h00, 8'h00, 8'h03}, '{8'h01, 8'h0F, 8'hC1}, '{8'h00, 8'h05, 8'hC3}, '{8'h08, 8'h0A, 8'h02},
		'{8'h08, 8'h03, 8'h41}, '{8'h00, 8'h0C, 8'h53}, '{8'h10, 8'h09, 8'h51}, '{8'h20, 8'h06, 8'h09},
		'{8'h00, 8'h07, 8'h0B}, '{8'h40, 8'h0B, 8'h0B}, '{8'h00, 8'h84, 8'h01}, '{8'h00, 8'h88, 8'h07},
		'{8'h00, 8'h91, 8'h23}, '{8'h80, 8'h0E, 8'h03}, '{8'h06, 8'h6D, 8'h03}, '{8'h00, 8'h02, 8'h61}};

	// switch banks come from the installer model
	aps_installer aps_installer_inst (.pol_set_i(pol_set), .adr_set_i(adr_set),
		.policy_bank_o(policy_switch_bank_i), .address_bank_o(address_switch_bank_i),
		.spare_bank_o(spare_switch_bank_i));
	aps_top aps_top_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.policy_switch_bank_i(policy_switch_bank_i),
		.address_switch_bank_i(address_switch_bank_i),
		.spare_switch_bank_i(spare_switch_bank_i), .escape_key_i(escape_key_i),
		.req_valid_i(req_valid_i), .req_exit_i(req_exit_i), .req_violation_i(req_violation_i),
		.req_tag_class_i(req_tag_class_i), .privileged_inside_i(privileged_inside_i),
		.buffer_full_i(buffer_full_i), .last_out_i(last_out_i),
		.table_check_done_i(table_check_done_i), .table_corrupt_i(table_corrupt_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .grant_o(grant_o), .deny_o(deny_o),
		.store_txn_o(store_txn_o), .store_unit_letter_o(store_unit_letter_o),
		.buffer_alarm_o(buffer_alarm_o), .arm_inputs_o(arm_inputs_o),
		.scanner_disable_mode_o(scanner_disable_mode_o), .unit_address_o(unit_address_o),
		.unit_letter_o(unit_letter_o), .settings_valid_o(settings_valid_o),
		.display_text_o(display_text_o), .reinit_tables_o(reinit_tables_o), .irq_o(irq_o));

	// 200 MHz clock
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic conclude();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// reset with new switch settings, then wait for the one sample
	task automatic restart(input aps_row_t x);
		@(posedge mclk_i);
		reset_n_i <= 1'h0;
		pol_set <= x.p;
		adr_set <= x.a;
		{buffer_full_i, privileged_inside_i} <= x.f[3:2];
		repeat (5) @(posedge mclk_i);
		@(negedge mclk_i);
		chk("blank", 32'h20202020, display_text_o);
		chk("valid in reset", 32'h0, 32'(settings_valid_o));
		@(posedge mclk_i);
		reset_n_i <= 1'h1;
		for (k = 0; k < 400 && settings_valid_o !== 1'h1; k++)
			@(negedge mclk_i);
		if (k == 400) begin
			chk("settle", 32'h1, 32'(settings_valid_o));
			conclude();
		end
	endtask

	task automatic req(input logic [7:0] f);
		@(posedge mclk_i);
		req_valid_i <= 1'h1;
		{req_exit_i, req_violation_i, req_tag_class_i} <= f[7:4];
		@(posedge mclk_i);
		req_valid_i <= 1'h0;
		@(negedge mclk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'h1;
		@(posedge mclk_i);
		reg_wr_i <= 1'h0;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'h1;
		@(posedge mclk_i);
		reg_rd_i <= 1'h0;
		@(negedge mclk_i);
		chk(nm, e, reg_rdata_o);
	endtask

	// table of settings and requests, then registers, interrupt and table fault
	initial begin
		foreach (rows[i]) begin
			r = rows[i];
			restart(r);
			am = r.a[3:0];
			lt = 8'h41 + {4'h0, am};
			chk("address", 32'(am), 32'(unit_address_o));
			chk("letter", 32'(lt), 32'(unit_letter_o));
			chk("report letter", 32'(lt), 32'(store_unit_letter_o));
			chk("display", {24'h416430, am > 4'h9 ? lt - 8'h0A : 8'h30 + {4'h0, am}},
				display_text_o);
			chk("scan mode", 32'(r.a[4]), 32'(scanner_disable_mode_o));
			req(r.f);
			chk("grant", 32'(r.f[1]), 32'(grant_o));
			chk("deny", 32'(!r.f[1]), 32'(deny_o));
			chk("store", 32'(r.f[0]), 32'(store_txn_o));
			chk("alarm", 32'(r.p[6] & r.f[3]), 32'(buffer_alarm_o));
			@(posedge mclk_i);
			last_out_i <= 1'h1;
			@(posedge mclk_i);
			last_out_i <= 1'h0;
			@(negedge mclk_i);
			chk("arm", 32'(r.p[7]), 32'(arm_inputs_o));
		end
		r = '{8'h40, 8'h0B, 8'h00};
		restart(r);
		@(posedge mclk_i);
		adr_set <= 8'h04;
		buffer_full_i <= 1'h1;
		wr(8'h00, 32'hFFFFFFFF);
		chk("masked irq", 32'h0, 32'(irq_o));
		chk("held address", 32'hB, 32'(unit_address_o));
		rd("status", 8'h04, 32'h1);
		rd("settings", 8'h00, 32'h01000B40);
		rd("report", 8'h10, 32'h00004C0B);
		rd("unmapped", 8'h14, 32'h0);
		wr(8'h0C, 32'h5);
		chk("irq", 32'h1, 32'(irq_o));
		wr(8'h08, 32'h1);
		chk("cleared irq", 32'h0, 32'(irq_o));
		@(posedge mclk_i);
		table_check_done_i <= 1'h1;
		table_corrupt_i <= 1'h1;
		@(posedge mclk_i);
		table_check_done_i <= 1'h0;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		chk("error text", 32'h45525231, display_text_o);
		chk("table irq", 32'h1, 32'(irq_o));
		@(posedge mclk_i);
		escape_key_i <= 1'h1;
		for (k = 0; k < 20 && reinit_tables_o !== 1'h1; k++)
			@(negedge mclk_i);
		chk("reinit", 32'h1, 32'(reinit_tables_o));
		@(posedge mclk_i);
		escape_key_i <= 1'h0;
		@(negedge mclk_i);
		chk("restored", 32'h41643042, display_text_o);
		conclude();
	end
endmodule
